// ### hdl/rsnt_defines.vh
`ifndef RSNT_DEFINES_VH
`define RSNT_DEFINES_VH

// Command codes that select a register
`define RSNT_CMD_WRITE_PROTECT   8'h10
`define RSNT_CMD_SETPOINT        8'h21
`define RSNT_CMD_SLEW            8'h27
`define RSNT_CMD_FAULT_THR       8'h4F
`define RSNT_CMD_WARN_THR        8'h51

// Reset values
`define RSNT_RST_WRITE_PROTECT   8'h00
`define RSNT_RST_SETPOINT        16'h00C8
`define RSNT_RST_SLEW            16'h0004
`define RSNT_RST_FAULT_THR       16'h0096
`define RSNT_RST_WARN_THR        16'h00E1

// Write-protect codes
`define RSNT_WP_ALL              8'h80
`define RSNT_WP_KEEP_OP          8'h40
`define RSNT_WP_KEEP_SETPOINT    8'h20

// Field positions
`define RSNT_SLEW_MSB            2
`define RSNT_THR_MSB             9
`define RSNT_SETPOINT_MSB        7
`define RSNT_DATA_W              16

// Timing: one 8 mV step at the slowest rate of 12.5 mV/ms
`define RSNT_CLK_MHZ             200
`define RSNT_STEP_UV             8000
`define RSNT_RATE0_UV_PER_MS     12500
`define RSNT_STEP_US_AT_RATE0    (`RSNT_STEP_UV * 1000 / `RSNT_RATE0_UV_PER_MS)
`define RSNT_BASE_STEP_CYC       (`RSNT_STEP_US_AT_RATE0 * `RSNT_CLK_MHZ)

`endif

// ### hdl/rsnt_ramp.v
`timescale 1ns/1ps
`include "rsnt_defines.vh"

module rsnt_ramp #(
    parameter integer P_BASE_STEP_CYC = `RSNT_BASE_STEP_CYC,
    parameter integer P_CNT_W         = 17,
    parameter integer P_REF_W         = 8,
    parameter integer P_SEL_W         = 3
) (
    // Clock and reset
    input  wire               i_core_clk,
    input  wire               i_rst,
    input  wire               i_ce,
    // Control
    input  wire               i_run,
    input  wire [P_REF_W-1:0] i_target,
    input  wire [P_SEL_W-1:0] i_rate_sel,
    // Result
    output reg  [P_REF_W-1:0] o_ref_code,
    output wire               o_ramping
);

    wire [31:0]        base32;
    wire [P_CNT_W-1:0] interval;
    reg  [P_CNT_W-1:0] cnt_r;
    reg                run_d_r;

    assign base32    = P_BASE_STEP_CYC;
    // Each code halves the step interval, doubling the rate
    assign interval  = base32[P_CNT_W-1:0] >> i_rate_sel;
    assign o_ramping = i_run & run_d_r & (o_ref_code != i_target);

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ref_code <= {P_REF_W{1'b0}};
            cnt_r      <= {P_CNT_W{1'b0}};
            run_d_r    <= 1'b0;
        end else if (i_ce) begin
            run_d_r <= i_run;
            if (!i_run) begin
                // Turn-off drops the reference at once, no slewing
                o_ref_code <= {P_REF_W{1'b0}};
                cnt_r      <= {P_CNT_W{1'b0}};
            end else if (!run_d_r) begin
                // Turn-on hands over the target directly; soft-start lies elsewhere
                o_ref_code <= i_target;
                cnt_r      <= {P_CNT_W{1'b0}};
            end else if (o_ref_code != i_target) begin
                // Compare with >= so a rate change mid-ramp cannot overshoot the count
                if (cnt_r >= interval - 1'b1) begin
                    cnt_r <= {P_CNT_W{1'b0}};
                    if (o_ref_code < i_target)
                        o_ref_code <= o_ref_code + 1'b1;
                    else
                        o_ref_code <= o_ref_code - 1'b1;
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end else begin
                cnt_r <= {P_CNT_W{1'b0}};
            end
        end
    end

endmodule // rsnt_ramp

// ### hdl/rsnt_regs.v
`timescale 1ns/1ps
`include "rsnt_defines.vh"

module rsnt_regs #(
    parameter integer P_BASE_STEP_CYC = `RSNT_BASE_STEP_CYC,
    parameter integer P_CNT_W         = 17
) (
    // Clock, reset and enable
    input  wire        i_core_clk,
    input  wire        i_rst,
    input  wire        i_ce,
    // Command port from the transaction engine
    input  wire [7:0]  i_cmd_code,
    input  wire        i_wr_en,
    input  wire [15:0] i_wr_data,
    input  wire        i_rd_en,
    output reg  [15:0] o_rd_data,
    output reg         o_rd_valid,
    output reg         o_wr_ack,
    output reg         o_wr_refused,
    output reg         o_cmd_unsupported,
    // Converter state
    input  wire        i_conv_on,
    // Thermistor sense
    input  wire [9:0]  i_thermistor_sense_code,
    // Results
    output wire [7:0]  o_output_reference_code,
    output wire        o_reference_ramping,
    output reg         o_external_overtemp_fault,
    output reg         o_external_overtemp_warning
);

    localparam integer SEL_W = `RSNT_SLEW_MSB + 1;
    localparam integer THR_W = `RSNT_THR_MSB + 1;
    localparam integer REF_W = `RSNT_SETPOINT_MSB + 1;
    localparam integer DW    = `RSNT_DATA_W;

    // Reset words are whole register images; only the stored field is kept
    localparam [DW-1:0] RST_SETPT = `RSNT_RST_SETPOINT;
    localparam [DW-1:0] RST_SLEW  = `RSNT_RST_SLEW;
    localparam [DW-1:0] RST_FLT   = `RSNT_RST_FAULT_THR;
    localparam [DW-1:0] RST_WRN   = `RSNT_RST_WARN_THR;

    // Stored fields
    reg [7:0]       write_protect_r;
    reg [REF_W-1:0] output_reference_setpoint_r;
    reg [SEL_W-1:0] reference_slew_rate_select_r;
    reg [THR_W-1:0] thermistor_fault_threshold_r;
    reg [THR_W-1:0] thermistor_warning_threshold_r;

    wire            cmd_known;
    wire            cmd_writable;

    // Is the command one of ours
    function is_mapped;
        input [7:0] cmd;
        begin
            case (cmd)
                `RSNT_CMD_WRITE_PROTECT: is_mapped = 1'b1;
                `RSNT_CMD_SETPOINT:      is_mapped = 1'b1;
                `RSNT_CMD_SLEW:          is_mapped = 1'b1;
                `RSNT_CMD_FAULT_THR:     is_mapped = 1'b1;
                `RSNT_CMD_WARN_THR:      is_mapped = 1'b1;
                default:                 is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Write permission under the current protect code
    function wr_allowed;
        input [7:0] cmd;
        input [7:0] wp;
        begin
            case (wp)
                `RSNT_WP_ALL:
                    wr_allowed = (cmd == `RSNT_CMD_WRITE_PROTECT);
                `RSNT_WP_KEEP_OP:
                    wr_allowed = (cmd == `RSNT_CMD_WRITE_PROTECT);
                `RSNT_WP_KEEP_SETPOINT:
                    wr_allowed = (cmd == `RSNT_CMD_WRITE_PROTECT) ||
                                 (cmd == `RSNT_CMD_SETPOINT);
                default:
                    wr_allowed = 1'b1;
            endcase
        end
    endfunction

    // Read image, unused bits forced to zero
    function [15:0] rd_image;
        input [7:0]       cmd;
        input [7:0]       wp;
        input [REF_W-1:0] setpt;
        input [SEL_W-1:0] slew;
        input [THR_W-1:0] flt;
        input [THR_W-1:0] wrn;
        begin
            case (cmd)
                `RSNT_CMD_WRITE_PROTECT:
                    rd_image = {8'h00, wp};
                `RSNT_CMD_SETPOINT:
                    rd_image = {{(DW-REF_W){1'b0}}, setpt};
                `RSNT_CMD_SLEW:
                    rd_image = {{(DW-SEL_W){1'b0}}, slew};
                `RSNT_CMD_FAULT_THR:
                    rd_image = {{(DW-THR_W){1'b0}}, flt};
                `RSNT_CMD_WARN_THR:
                    rd_image = {{(DW-THR_W){1'b0}}, wrn};
                default:
                    rd_image = 16'h0000;
            endcase
        end
    endfunction

    assign cmd_known    = is_mapped(i_cmd_code);
    assign cmd_writable = wr_allowed(i_cmd_code, write_protect_r);

    // Register writes
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            write_protect_r                <= `RSNT_RST_WRITE_PROTECT;
            output_reference_setpoint_r    <= RST_SETPT[REF_W-1:0];
            reference_slew_rate_select_r   <= RST_SLEW[SEL_W-1:0];
            thermistor_fault_threshold_r   <= RST_FLT[THR_W-1:0];
            thermistor_warning_threshold_r <= RST_WRN[THR_W-1:0];
        end else if (i_ce && i_wr_en && cmd_known && cmd_writable) begin
            case (i_cmd_code)
                `RSNT_CMD_WRITE_PROTECT:
                    write_protect_r <= i_wr_data[7:0];
                `RSNT_CMD_SETPOINT:
                    output_reference_setpoint_r <= i_wr_data[`RSNT_SETPOINT_MSB:0];
                `RSNT_CMD_SLEW:
                    reference_slew_rate_select_r <= i_wr_data[`RSNT_SLEW_MSB:0];
                `RSNT_CMD_FAULT_THR:
                    thermistor_fault_threshold_r <= i_wr_data[`RSNT_THR_MSB:0];
                `RSNT_CMD_WARN_THR:
                    thermistor_warning_threshold_r <= i_wr_data[`RSNT_THR_MSB:0];
                default: ;
            endcase
        end
    end

    // Write answer strobes
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wr_ack     <= 1'b0;
            o_wr_refused <= 1'b0;
        end else if (i_ce) begin
            o_wr_ack     <= i_wr_en & cmd_known & cmd_writable;
            // A protected write is dropped but still answered so the host can see it
            o_wr_refused <= i_wr_en & cmd_known & ~cmd_writable;
        end
    end

    // Read path; reads are never blocked by write protection
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data  <= 16'h0000;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_image(i_cmd_code,
                                      write_protect_r,
                                      output_reference_setpoint_r,
                                      reference_slew_rate_select_r,
                                      thermistor_fault_threshold_r,
                                      thermistor_warning_threshold_r);
            end
        end
    end

    // Unsupported command flag
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cmd_unsupported <= 1'b0;
        end else if (i_ce) begin
            o_cmd_unsupported <= (i_wr_en | i_rd_en) & ~cmd_known;
        end
    end

    // Thermistor comparators; a falling voltage means rising temperature
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_external_overtemp_fault   <= 1'b0;
            o_external_overtemp_warning <= 1'b0;
        end else if (i_ce) begin
            o_external_overtemp_fault <=
                (i_thermistor_sense_code < thermistor_fault_threshold_r);
            o_external_overtemp_warning <=
                (i_thermistor_sense_code < thermistor_warning_threshold_r);
        end
    end

    // Reference ramp generator
    rsnt_ramp #(
        .P_BASE_STEP_CYC (P_BASE_STEP_CYC),
        .P_CNT_W         (P_CNT_W),
        .P_REF_W         (REF_W),
        .P_SEL_W         (SEL_W)
    ) u_ramp (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_run      (i_conv_on),
        .i_target   (output_reference_setpoint_r),
        .i_rate_sel (reference_slew_rate_select_r),
        .o_ref_code (o_output_reference_code),
        .o_ramping  (o_reference_ramping)
    );

endmodule // rsnt_regs

// ### sim/rsnt_host.sv
`timescale 1ns/1ps
module rsnt_host (
    // Clock
    input  wire        i_core_clk,
    // Command port toward the device
    output reg  [7:0]  o_cmd,
    output reg         o_wr,
    output reg         o_rd,
    output reg  [15:0] o_data,
    input  wire [15:0] i_rdata
);
    initial begin
        o_cmd = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_data = 16'h0000;
    end

    // Both bytes always travel together as one word
    task wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge i_core_clk);
        o_cmd = c;
        o_data = d;
        o_wr = 1'b1;
        @(negedge i_core_clk);
        o_wr = 1'b0;
        o_data = ~d;
    endtask

    task rd(input logic [7:0] c, output logic [15:0] d);
        @(negedge i_core_clk);
        o_cmd = c;
        o_rd = 1'b1;
        @(negedge i_core_clk);
        o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule // rsnt_host

// ### sim/rsnt_regs_sva.sv
`timescale 1ns/1ps
module rsnt_regs_chk (
    // Clock and requests
    input wire        i_core_clk,
    input wire        i_rst,
    input wire        i_ce,
    input wire [7:0]  i_cmd_code,
    input wire        i_wr_en,
    input wire        i_rd_en,
    input wire        i_conv_on,
    // Answers
    input wire [15:0] o_rd_data,
    input wire        o_rd_valid,
    input wire        o_wr_ack,
    input wire        o_wr_refused,
    input wire        o_cmd_unsupported,
    input wire [7:0]  o_output_reference_code,
    input wire        o_reference_ramping,
    input wire        o_external_overtemp_fault
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire [7:0] rc = o_output_reference_code;
    reg  [1:0] on_q;
    // Masks the load of the setpoint at turn-on, which is a legal jump
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) on_q <= 2'b00;
        else on_q <= {on_q[0], i_conv_on};
    end

    rd_answer_a: assert property (i_ce && i_rd_en |=> o_rd_valid)
        else $error("read not answered");
    wr_answer_a: assert property (i_ce && i_wr_en
        |=> $onehot({o_wr_ack, o_wr_refused, o_cmd_unsupported}))
        else $error("write answer wrong");
    slew_bits_a: assert property (i_ce && i_rd_en && i_cmd_code == 8'h27
        |=> o_rd_data[15:3] == 13'h0000)
        else $error("slew upper bits set");
    thr_bits_a: assert property (i_ce && i_rd_en && (i_cmd_code == 8'h4F || i_cmd_code == 8'h51)
        |=> o_rd_data[15:10] == 6'h00)
        else $error("threshold upper bits set");
    unmap_zero_a: assert property (i_ce && i_rd_en && i_cmd_code == 8'h33
        |=> o_cmd_unsupported && o_rd_data == 16'h0000)
        else $error("unmapped read wrong");
    ref_off_a: assert property (i_ce && !i_conv_on |=> rc == 8'h00)
        else $error("reference not zero when off");
    step_one_a: assert property (i_conv_on && &on_q && rc != $past(rc)
        |-> rc == $past(rc) + 8'h01 || rc == $past(rc) - 8'h01)
        else $error("reference jumped");
    step_gap_a: assert property (i_conv_on && &on_q && $changed(rc)
        |=> $stable(rc) || !$past(i_conv_on))
        else $error("steps too close");
    ramp_flag_a: assert property (!i_conv_on |-> !o_reference_ramping)
        else $error("ramping while off");
    // Once settled on the setpoint the reference must not wander
    idle_hold_a: assert property (i_ce && $past(i_ce) && i_conv_on && $past(i_conv_on)
        && !o_reference_ramping |=> $stable(rc))
        else $error("reference moved while settled");

    cover property (o_wr_refused);
    cover property ($rose(o_external_overtemp_fault));
    cover property (o_reference_ramping && $changed(rc));
endmodule // rsnt_regs_chk

bind rsnt_regs rsnt_regs_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_cmd_code(i_cmd_code), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_conv_on(i_conv_on),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_wr_ack(o_wr_ack),
    .o_wr_refused(o_wr_refused), .o_cmd_unsupported(o_cmd_unsupported),
    .o_output_reference_code(o_output_reference_code),
    .o_reference_ramping(o_reference_ramping),
    .o_external_overtemp_fault(o_external_overtemp_fault));

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        on = 1'b0;
    logic [9:0]  sense = 10'h3FF;
    logic [7:0]  cmd;
    logic        wr;
    logic        rd;
    logic [15:0] wd;
    logic [15:0] rdat;
    logic [7:0]  ref_code;
    logic [7:0]  r0;
    logic        flt;
    logic        wrn;
    logic [9:0]  tv [4] = '{10'h095, 10'h096, 10'h0E0, 10'h0E1};
    int          n_fail = 0;
    int          total_checks = 0;
    int          k;
    int          n;

    always #2.5 clk = ~clk;

    rsnt_host u_host (.i_core_clk(clk), .o_cmd(cmd), .o_wr(wr), .o_rd(rd), .o_data(wd),
        .i_rdata(rdat));
    // Short step base keeps the slowest ramp code to a few hundred cycles
    rsnt_regs #(.P_BASE_STEP_CYC(256)) u_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_cmd_code(cmd), .i_wr_en(wr), .i_wr_data(wd), .i_rd_en(rd), .o_rd_data(rdat),
        .o_rd_valid(), .o_wr_ack(), .o_wr_refused(), .o_cmd_unsupported(), .i_conv_on(on),
        .i_thermistor_sense_code(sense), .o_output_reference_code(ref_code),
        .o_reference_ramping(), .o_external_overtemp_fault(flt),
        .o_external_overtemp_warning(wrn));

    task automatic chkrd(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] v;
        u_host.rd(c, v);
        `CHK($sformatf("reg %h", c), e, v)
    endtask

    task automatic step(output int c);
        logic [7:0] s;
        s = ref_code;
        c = 0;
        while (ref_code === s && c < 600) begin
            @(negedge clk);
            c++;
        end
    endtask

    task final_report;
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        final_report;
    end

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chkrd(8'h27, 16'h0004);
        chkrd(8'h4F, 16'h0096);
        chkrd(8'h51, 16'h00E1);
        chkrd(8'h21, 16'h00C8);
        u_host.wr(8'h27, 16'hFFFF);
        chkrd(8'h27, 16'h0007);
        u_host.wr(8'h4F, 16'hFC00);
        chkrd(8'h4F, 16'h0000);
        u_host.wr(8'h4F, 16'hFFFF);
        chkrd(8'h4F, 16'h03FF);
        u_host.wr(8'h51, 16'h7FFF);
        chkrd(8'h51, 16'h03FF);
        u_host.wr(8'h21, 16'hFFFF);
        chkrd(8'h21, 16'h00FF);
        u_host.wr(8'h33, 16'h1234);
        chkrd(8'h33, 16'h0000);
        u_host.wr(8'h4F, 16'h0096);
        u_host.wr(8'h51, 16'h00E1);
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            sense = tv[k];
            repeat (2) @(negedge clk);
            `CHK("fault", k == 0, flt)
            `CHK("warn", k < 3, wrn)
        end
        u_host.wr(8'h10, 16'h0020);
        u_host.wr(8'h27, 16'h0001);
        u_host.wr(8'h4F, 16'h0200);
        u_host.wr(8'h21, 16'h0010);
        chkrd(8'h27, 16'h0007);
        chkrd(8'h4F, 16'h0096);
        chkrd(8'h21, 16'h0010);
        u_host.wr(8'h10, 16'h0000);
        u_host.wr(8'h4F, 16'h0200);
        repeat (2) @(negedge clk);
        `CHK("fault", 1'b1, flt)
        on = 1'b1;
        @(negedge clk);
        `CHK("ref on", 8'h10, ref_code)
        on = 1'b0;
        @(negedge clk);
        `CHK("ref off", 8'h00, ref_code)
        on = 1'b1;
        @(negedge clk);
        `CHK("ref on", 8'h10, ref_code)
        for (k = 0; k < 8; k++) begin
            r0 = ref_code;
            u_host.wr(8'h27, k[15:0]);
            u_host.wr(8'h21, {8'h00, r0 + 8'h02});
            step(n);
            `CHK("first step", r0 + 8'h01, ref_code)
            `CHK("first gap", 256 >> k, n)
            step(n);
            `CHK("interval", 256 >> k, n)
        end
        final_report;
    end
endmodule // tb
